// File: rtl/tsr_regmap.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsr_cfg.svh"

// How it works
// - scl low 30ms in frame: reset, release
// - 8-bit pointer, low bits pick register
// - pointer select resets to temperature result
// - select 0 temp,1 config,2 low,3 high
// - result read-only, latest conversion, 12/13 bits
// - result sent msb first, host may stop
// - result low bit shows extended range
// - result left-justified, unused low bits zero
// - limits same format, bit 0 zero
// - limits reset to +80 and +75 degC
// - config 16-bit read/write, msb first
// - conversion flag reads 1 when idle
// - resolution bits read 11 always
// - fault count field, default 00
// - polarity bit, default low-active alert
// - alert mode bit, default comparator
// - shutdown bit, default continuous conversion
// - rate field, default 4Hz
// - reads use last pointer value
module tsr_regmap #(
    parameter int unsigned TOUT_CYC = `TSR_TOUT_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic [1:0] i_addr_strap,
    input wire logic [12:0] i_temp_code,
    input wire logic i_conv_done,
    input wire logic i_conv_busy,
    input wire logic i_alarm_flag,
    output tsr_pkg::tsr_ctrl_t o_ctrl,
    output logic [12:0] o_lower_limit,
    output logic [12:0] o_upper_limit,
    output logic [1:0] o_reg_sel
);
    import tsr_pkg::*;

    // pin synchronisers: first stage is only read by the second
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic [1:0] strap_m_q, strap_s_q;

    // bus events seen on the synchronised pins
    logic scl_rise, scl_fall, bus_start, bus_stop, tout;

    // slave state
    tsr_state_t st_q, st_d, nxt_q, nxt_d;
    logic [2:0] cnt_q, cnt_d; // bit index in the byte
    logic [7:0] sh_q, sh_d; // receive shift register
    logic [7:0] tx_q, tx_d; // transmit shift register
    logic rw_q, rw_d; // direction from the address byte
    logic byte_q, byte_d; // 0 = msb byte, 1 = lsb byte
    logic ack_q, ack_d; // acknowledge the byte just taken
    logic ph_q, ph_d; // 1 while the ack bit is on the wire
    logic oe_q, oe_d; // sda pulled low
    logic [7:0] hold_q, hold_d; // msb of a register write
    logic [15:0] snap_q, snap_d; // word frozen for the read
    logic in_frame_q; // between start and stop

    // register storage
    logic [7:0] ptr_q; // pointer register
    logic [12:0] temp_q; // latest conversion result
    logic [12:0] low_q, high_q; // alarm limits
    logic conv_flag_q; // conversion flag bit
    tsr_ctrl_t ctrl_q; // writable config fields

    // decode and read formatting
    logic [1:0] sel;
    logic [6:0] my_addr;
    logic [7:0] rx_byte;
    logic [15:0] wr_word, rd_word;
    logic [15:0] temp_word, cfg_word, low_word, high_word;
    logic [12:0] lim_in;
    logic [7:0] rd_byte;
    logic ptr_done, wr_commit;
    logic em;

    // two flops on every pin before any logic looks at it
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
            strap_m_q <= 2'h0;
            strap_s_q <= 2'h0;
        end else begin
            {scl_m_q, scl_s_q, scl_p_q} <= {i_scl, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_p_q} <= {i_sda, sda_m_q, sda_s_q};
            strap_m_q <= i_addr_strap;
            strap_s_q <= strap_m_q;
        end
    end

    assign scl_rise = scl_s_q && !scl_p_q;
    assign scl_fall = !scl_s_q && scl_p_q;
    // start and stop are sda edges while scl stays high
    assign bus_start = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    assign bus_stop = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
    assign my_addr = {`TSR_ADDR_BASE, strap_s_q};
    assign rx_byte = {sh_q[6:0], sda_s_q};

    // watchdog on scl held low inside a frame
    tsr_timeout #(
        .TOUT_CYC(TOUT_CYC)
    ) i_tsr_timeout (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_arm(in_frame_q && !scl_s_q),
        .o_expired(tout)
    );

    // frame tracking: a timeout ends the frame like a stop
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            in_frame_q <= 1'b0;
        end else if (bus_stop || tout) begin
            in_frame_q <= 1'b0;
        end else if (bus_start) begin
            in_frame_q <= 1'b1;
        end
    end

    // register selection and formatting
    assign sel = ptr_q[1:0];
    assign em = ctrl_q.extended_range_bit;
    assign temp_word = em ? {temp_q, 3'h1} : {temp_q[11:0], 4'h0};
    assign low_word = em ? {low_q, 3'h0} : {low_q[11:0], 4'h0};
    assign high_word = em ? {high_q, 3'h0} : {high_q[11:0], 4'h0};
    assign cfg_word = {conv_flag_q, `TSR_RES_BITS, ctrl_q.fault_count_field,
                       ctrl_q.alert_polarity_bit, ctrl_q.alert_mode_bit,
                       ctrl_q.shutdown_bit, ctrl_q.conversion_rate_field,
                       i_alarm_flag, em, 4'h0};
    assign rd_word = (sel == `TSR_SEL_TEMP) ? temp_word :
                     (sel == `TSR_SEL_CFG) ? cfg_word :
                     (sel == `TSR_SEL_LOW) ? low_word : high_word;
    assign rd_byte = byte_q ? snap_q[7:0] : snap_q[15:8];
    assign wr_word = {hold_q, rx_byte};
    // normal range sign-extends the 12-bit code into 13 bits
    assign lim_in = em ? wr_word[15:3] : {wr_word[15], wr_word[15:4]};

    // byte engine: data is sampled on scl rise and driven on scl fall
    always_comb begin
        st_d = st_q;
        nxt_d = nxt_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        rw_d = rw_q;
        byte_d = byte_q;
        ack_d = ack_q;
        ph_d = ph_q;
        oe_d = oe_q;
        hold_d = hold_q;
        snap_d = snap_q;
        ptr_done = 1'b0;
        wr_commit = 1'b0;
        if (bus_stop || tout) begin
            st_d = TSR_ST_IDLE;
            oe_d = 1'b0;
            ph_d = 1'b0;
        end else if (bus_start) begin
            st_d = TSR_ST_ADDR; // repeated start also lands here
            cnt_d = 3'h0;
            oe_d = 1'b0;
            ph_d = 1'b0;
        end else begin
            case (st_q)
                TSR_ST_ADDR, TSR_ST_PTR, TSR_ST_WRD: begin
                    if (scl_rise) begin
                        sh_d = rx_byte;
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            st_d = TSR_ST_ACK_TX;
                            ack_d = 1'b1;
                            if (st_q == TSR_ST_ADDR) begin
                                ack_d = (sh_q[6:0] == my_addr);
                                rw_d = sda_s_q;
                                byte_d = 1'b0;
                                // frozen now so both bytes belong together
                                snap_d = rd_word;
                                nxt_d = sda_s_q ? TSR_ST_RD : TSR_ST_PTR;
                            end else if (st_q == TSR_ST_PTR) begin
                                ptr_done = 1'b1;
                                byte_d = 1'b0;
                                nxt_d = TSR_ST_WRD;
                            end else begin
                                hold_d = byte_q ? hold_q : rx_byte;
                                wr_commit = byte_q;
                                byte_d = !byte_q;
                                nxt_d = TSR_ST_WRD;
                            end
                        end
                    end
                end
                TSR_ST_ACK_TX: begin
                    if (scl_fall && !ph_q) begin
                        ph_d = 1'b1;
                        oe_d = ack_q;
                        if (!ack_q) begin
                            st_d = TSR_ST_IDLE; // not ours: stay off the bus
                        end
                    end else if (scl_fall) begin
                        ph_d = 1'b0;
                        cnt_d = 3'h0;
                        st_d = nxt_q;
                        oe_d = 1'b0;
                        if (nxt_q == TSR_ST_RD) begin
                            tx_d = rd_byte;
                            oe_d = !rd_byte[7];
                        end
                    end
                end
                TSR_ST_RD: begin
                    if (scl_fall && cnt_q == 3'h0 && ph_q) begin
                        ph_d = 1'b0;
                        tx_d = rd_byte;
                        oe_d = !rd_byte[7];
                    end else if (scl_fall && cnt_q != 3'h0) begin
                        tx_d = {tx_q[6:0], 1'b0};
                        oe_d = !tx_q[6];
                    end else if (scl_rise) begin
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            st_d = TSR_ST_ACK_RX;
                        end
                    end
                end
                TSR_ST_ACK_RX: begin
                    if (scl_fall) begin
                        oe_d = 1'b0; // host owns the ack bit
                    end else if (scl_rise) begin
                        cnt_d = 3'h0;
                        byte_d = !byte_q;
                        ph_d = 1'b1; // next fall loads the next byte
                        // a nack lets the host stop after any byte
                        st_d = sda_s_q ? TSR_ST_IDLE : TSR_ST_RD;
                    end
                end
                default: begin
                    st_d = st_q; // idle waits for a start
                end
            endcase
        end
    end

    // slave state registers
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= TSR_ST_IDLE;
            nxt_q <= TSR_ST_IDLE;
            {cnt_q, rw_q, byte_q, ack_q, ph_q, oe_q} <= 8'h00;
            {sh_q, tx_q, hold_q} <= 24'h000000;
            snap_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            nxt_q <= nxt_d;
            {cnt_q, rw_q, byte_q, ack_q, ph_q, oe_q} <= {cnt_d, rw_d, byte_d, ack_d, ph_d, oe_d};
            {sh_q, tx_q, hold_q} <= {sh_d, tx_d, hold_d};
            snap_q <= snap_d;
        end
    end

    // pointer: all eight bits kept, only the low two decode
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ptr_q <= `TSR_PTR_RST;
        end else if (ptr_done) begin
            ptr_q <= rx_byte;
        end
    end

    // result register: only the converter writes it
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            temp_q <= 13'h0000;
            conv_flag_q <= 1'b0;
        end else begin
            conv_flag_q <= !i_conv_busy;
            if (i_conv_done) begin
                temp_q <= i_temp_code;
            end
        end
    end

    // writable registers: a word lands only once its lsb byte arrives
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            low_q <= `TSR_LOW_RST;
            high_q <= `TSR_HIGH_RST;
            ctrl_q.conversion_rate_field <= `TSR_RATE_RST;
            ctrl_q.fault_count_field <= `TSR_FAULT_RST;
            ctrl_q.alert_polarity_bit <= 1'b0;
            ctrl_q.alert_mode_bit <= 1'b0;
            ctrl_q.shutdown_bit <= 1'b0;
            ctrl_q.extended_range_bit <= 1'b0;
        end else if (wr_commit) begin
            if (sel == `TSR_SEL_LOW) begin
                low_q <= lim_in;
            end else if (sel == `TSR_SEL_HIGH) begin
                high_q <= lim_in;
            end else if (sel == `TSR_SEL_CFG) begin
                // flag, resolution and alarm bits are not stored
                ctrl_q.fault_count_field <= wr_word[12:11];
                ctrl_q.alert_polarity_bit <= wr_word[10];
                ctrl_q.alert_mode_bit <= wr_word[9];
                ctrl_q.shutdown_bit <= wr_word[8];
                ctrl_q.conversion_rate_field <= wr_word[7:6];
                ctrl_q.extended_range_bit <= wr_word[4];
            end
        end
    end

    // outputs: open drain, so the data level is always low
    assign o_sda_o = 1'b0;
    assign o_sda_oe = oe_q;
    assign o_ctrl = ctrl_q;
    assign o_lower_limit = low_q;
    assign o_upper_limit = high_q;
    assign o_reg_sel = sel;

    // checks
    property p_tout_release;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        tout |=> (st_q == TSR_ST_IDLE) && !o_sda_oe && !in_frame_q;
    endproperty
    a_tout_release: assert property (p_tout_release) else $error("timeout left bus held");

    property p_ptr_only_on_byte;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        !$stable(ptr_q) |-> $past(ptr_done) && ptr_q == $past(rx_byte);
    endproperty
    a_ptr_only_on_byte: assert property (p_ptr_only_on_byte) else $error("pointer moved");

    property p_sel_temp_fmt;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (sel == `TSR_SEL_TEMP) |-> (em ? rd_word[15:3] == temp_q && rd_word[2:0] == 3'h1
                                       : rd_word[15:4] == temp_q[11:0] && rd_word[3:0] == 4'h0);
    endproperty
    a_sel_temp_fmt: assert property (p_sel_temp_fmt) else $error("result format wrong");

    property p_em_flag;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (sel == `TSR_SEL_TEMP) |-> rd_word[0] == em;
    endproperty
    a_em_flag: assert property (p_em_flag) else $error("range flag wrong");

    property p_limit_lsb;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        sel[1] |-> rd_word[0] == 1'b0 && (em || rd_word[3:0] == 4'h0);
    endproperty
    a_limit_lsb: assert property (p_limit_lsb) else $error("limit low bits set");

    property p_res_bits;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (sel == `TSR_SEL_CFG) |-> rd_word[14:13] == 2'h3 && rd_word[15] == conv_flag_q;
    endproperty
    a_res_bits: assert property (p_res_bits) else $error("config read-only bits wrong");

    property p_temp_ro;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (wr_commit && sel == `TSR_SEL_TEMP && !i_conv_done) |=> $stable(temp_q);
    endproperty
    a_temp_ro: assert property (p_temp_ro) else $error("result changed by write");

    property p_cfg_write;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (wr_commit && sel == `TSR_SEL_CFG) |=>
            ctrl_q.fault_count_field == $past(wr_word[12:11]) &&
            ctrl_q.shutdown_bit == $past(wr_word[8]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_msb_first;
        @(posedge i_clk_sys) disable iff (!i_rst_b)
        (st_q == TSR_ST_ACK_TX && ph_q && scl_fall && nxt_q == TSR_ST_RD && !bus_stop && !tout
         && !bus_start) |=> tx_q == snap_q[15:8];
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("read did not start at msb");

endmodule
`default_nettype wire

// File: rtl/tsr_cfg.svh
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH

// register select codes carried in the low two pointer bits
`define TSR_SEL_TEMP 2'h0
`define TSR_SEL_CFG 2'h1
`define TSR_SEL_LOW 2'h2
`define TSR_SEL_HIGH 2'h3

// pointer and selection reset values
`define TSR_PTR_RST 8'h00

// limit reset codes at 0.0625 degC per lsb: +75 degC and +80 degC
`define TSR_LOW_RST 13'h04B0
`define TSR_HIGH_RST 13'h0500

// configuration reset values
`define TSR_RATE_RST 2'h2
`define TSR_FAULT_RST 2'h0
`define TSR_RES_BITS 2'h3

// two-wire address: fixed upper five bits, strap fills the low two
`define TSR_ADDR_BASE 5'h12

// bus timeout on scl held low inside a frame
`define TSR_TOUT_MS 30
`define TSR_CLK_KHZ 200000
`define TSR_TOUT_CYC (`TSR_TOUT_MS * `TSR_CLK_KHZ)

`endif

// File: rtl/tsr_pkg.sv
package tsr_pkg;

    // byte-level state of the two-wire slave
    typedef enum logic [2:0] {
        TSR_ST_IDLE,
        TSR_ST_ADDR,
        TSR_ST_PTR,
        TSR_ST_WRD,
        TSR_ST_ACK_TX,
        TSR_ST_RD,
        TSR_ST_ACK_RX
    } tsr_state_t;

    // control fields handed to conversion and alert logic
    typedef struct packed {
        logic [1:0] conversion_rate_field;
        logic [1:0] fault_count_field;
        logic alert_polarity_bit;
        logic alert_mode_bit;
        logic shutdown_bit;
        logic extended_range_bit;
    } tsr_ctrl_t;

endpackage

// File: rtl/tsr_timeout.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsr_cfg.svh"

// counts system cycles while armed, pulses once when the limit is reached
module tsr_timeout #(
    parameter int unsigned TOUT_CYC = `TSR_TOUT_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_arm,
    output logic o_expired
);
    import tsr_pkg::*;

    logic [22:0] cnt_q; // cycles spent armed
    logic [22:0] cnt_d;
    logic hit; // limit reached this cycle

    assign hit = i_arm && (cnt_q == 23'(TOUT_CYC - 1));
    // counter parks one past the last count, so only one pulse leaves per hold
    assign cnt_d = !i_arm ? 23'h000000 :
                   ((cnt_q == 23'(TOUT_CYC)) ? cnt_q : cnt_q + 23'h000001);

    // disarm clears the count, so any scl edge restarts the wait
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= 23'h000000;
            o_expired <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            o_expired <= hit;
        end
    end

endmodule
`default_nettype wire

// File: testbench/tsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// bit-banged two-wire bus host, one bit every 160 ns of bus clock
module tsr_host_model (
    input wire logic i_clk_sys,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    // bus clock stands high and data is released outside frames
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end

    // a quarter bit: eight system cycles, well past the device's pin delay
    task automatic qtr();
        repeat (8) @(posedge i_clk_sys);
    endtask

    // data changes only while the clock is low; the bit ends with the clock low
    task automatic tx_bit(input logic b);
        o_sda_oe <= ~b;
        qtr();
        o_scl <= 1'b1;
        qtr();
        qtr();
        o_scl <= 1'b0;
        qtr();
    endtask

    // released line, sampled in the middle of the high phase
    task automatic rx_bit(output logic b);
        o_sda_oe <= 1'b0;
        qtr();
        o_scl <= 1'b1;
        qtr();
        b = i_sda;
        qtr();
        o_scl <= 1'b0;
        qtr();
    endtask

    // start, also usable as a repeated start from a low clock
    task automatic bus_start();
        o_sda_oe <= 1'b0;
        qtr();
        o_scl <= 1'b1;
        qtr();
        o_sda_oe <= 1'b1;
        qtr();
        o_scl <= 1'b0;
        qtr();
    endtask

    // stop: data rises while the clock is high
    task automatic bus_stop();
        o_sda_oe <= 1'b1;
        qtr();
        o_scl <= 1'b1;
        qtr();
        o_sda_oe <= 1'b0;
        qtr();
    endtask

    // byte out msb first, ack low means taken
    task automatic wr_byte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            tx_bit(v[i]);
        end
        rx_bit(ack);
    endtask

    // byte in msb first, then ack or nack from the host
    task automatic rd_byte(input logic last, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            rx_bit(v[i]);
        end
        tx_bit(last);
    endtask
endmodule

`default_nettype wire

// File: testbench/tsr_regmap_test.sv
`timescale 1ns/1ps
`default_nettype none

module tsr_regmap_test;
    import tsr_pkg::*;
    localparam int unsigned TOUT = 200; // short bus timeout keeps the run brief
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic [12:0] temp_code = 13'h0000; // conversion result fed in
    logic conv_done = 1'b0;
    logic conv_busy = 1'b0;
    logic alarm = 1'b1;
    logic scl;
    logic host_oe;
    logic sda_o;
    logic sda_oe;
    tsr_ctrl_t ctrl;
    logic [12:0] low_lim;
    logic [12:0] up_lim;
    logic [1:0] reg_sel;
    int n_errors = 0;
    int cmp_count = 0;
    // pulled-up open-drain data line, low if either side pulls
    wire logic sda = ~(host_oe | sda_oe);

    tsr_regmap #(.TOUT_CYC(TOUT)) i_tsr_regmap (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda),
        .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_addr_strap(2'h1),
        .i_temp_code(temp_code), .i_conv_done(conv_done), .i_conv_busy(conv_busy),
        .i_alarm_flag(alarm), .o_ctrl(ctrl), .o_lower_limit(low_lim),
        .o_upper_limit(up_lim), .o_reg_sel(reg_sel)
    );

    tsr_host_model i_tsr_host_model (
        .i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe)
    );

    // 200 MHz system clock
    initial begin
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    task automatic complete_run();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t saw %h wanted %h", $time, seen, exp);
        end
    endtask

    // one conversion result handed over by a single-cycle pulse
    task automatic conv(input logic [12:0] code);
        temp_code <= code;
        conv_done <= 1'b1;
        @(posedge i_clk_sys);
        conv_done <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    // address 0x49 from strap 01; data bytes are acked even for register 0, only address and pointer acks are checked
    task automatic wr_reg(input logic [1:0] sel, input logic [15:0] v);
        logic a0;
        logic a1;
        logic a2;
        i_tsr_host_model.bus_start();
        i_tsr_host_model.wr_byte(8'h92, a0);
        i_tsr_host_model.wr_byte({6'h00, sel}, a1);
        i_tsr_host_model.wr_byte(v[15:8], a2);
        i_tsr_host_model.wr_byte(v[7:0], a2);
        i_tsr_host_model.bus_stop();
        chk({14'h0000, a0, a1}, 16'h0000);
    endtask

    // optional pointer write, then a repeated-start read of one word
    task automatic rd_reg(input logic setp, input logic [1:0] sel, output logic [15:0] v);
        logic a;
        logic [7:0] m;
        logic [7:0] l;
        if (setp) begin
            i_tsr_host_model.bus_start();
            i_tsr_host_model.wr_byte(8'h92, a);
            i_tsr_host_model.wr_byte({6'h00, sel}, a);
        end
        i_tsr_host_model.bus_start();
        i_tsr_host_model.wr_byte(8'h93, a);
        i_tsr_host_model.rd_byte(1'b0, m);
        i_tsr_host_model.rd_byte(1'b1, l);
        i_tsr_host_model.bus_stop();
        v = {m, l};
    endtask

    // power-up values, and a read that never set the pointer
    task automatic t_reset();
        logic [15:0] v;
        chk({14'h0000, reg_sel}, 16'h0000);
        chk({15'h0000, sda_o}, 16'h0000);
        chk({3'h0, low_lim}, 16'h04B0);
        chk({3'h0, up_lim}, 16'h0500);
        chk({8'h00, ctrl}, 16'h0080);
        conv(13'h0190);
        rd_reg(1'b0, 2'h0, v);
        chk(v, 16'h1900);
        rd_reg(1'b1, 2'h1, v);
        chk(v, 16'hE0A0);
    endtask

    // every fault count and rate code, read-only bits written as ones
    task automatic t_cfg();
        logic [1:0] f;
        logic [15:0] v;
        conv_busy <= 1'b1;
        alarm <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            f = k[1:0];
            wr_reg(2'h1, {3'b111, f, f[0], f[1], f[0], f, 1'b1, f[1], 4'hF});
            chk({8'h00, ctrl}, {8'h00, f, f, f[0], f[1], f[0], f[1]});
            rd_reg(1'b0, 2'h1, v);
            chk(v, {1'b0, 2'b11, f, f[0], f[1], f[0], f, 1'b0, f[1], 4'h0});
        end
    endtask

    // extended result, refused result write, and a one-byte read
    task automatic t_ext();
        logic [15:0] v;
        logic [7:0] m;
        logic a;
        conv(13'h0A50);
        rd_reg(1'b1, 2'h0, v);
        chk(v, 16'h5281);
        wr_reg(2'h0, 16'h1234);
        rd_reg(1'b0, 2'h0, v);
        chk(v, 16'h5281);
        chk({14'h0000, reg_sel}, 16'h0000);
        i_tsr_host_model.bus_start();
        i_tsr_host_model.wr_byte(8'h93, a);
        i_tsr_host_model.rd_byte(1'b1, m);
        i_tsr_host_model.bus_stop();
        chk({8'h00, m}, 16'h0052);
    endtask

    // limits in both formats, a negative code among them
    task automatic t_lim();
        logic [15:0] v;
        wr_reg(2'h3, 16'h5000);
        chk({3'h0, up_lim}, 16'h0A00);
        rd_reg(1'b1, 2'h3, v);
        chk(v, 16'h5000);
        wr_reg(2'h1, 16'h0080);
        wr_reg(2'h2, 16'hE700);
        chk({3'h0, low_lim}, 16'h1E70);
        rd_reg(1'b1, 2'h2, v);
        chk(v, 16'hE700);
        rd_reg(1'b1, 2'h3, v);
        chk(v, 16'hA000);
    endtask

    // clock held low during the address ack until the interface gives up
    task automatic t_tout();
        logic [15:0] v;
        logic [7:0] adr;
        adr = 8'h92;
        i_tsr_host_model.bus_start();
        for (int i = 7; i >= 0; i--) begin
            i_tsr_host_model.tx_bit(adr[i]);
        end
        @(negedge i_clk_sys);
        chk({15'h0000, sda_oe}, 16'h0001);
        repeat (TOUT + 40) @(negedge i_clk_sys);
        chk({15'h0000, sda_oe}, 16'h0000);
        @(posedge i_clk_sys);
        i_tsr_host_model.bus_stop();
        rd_reg(1'b1, 2'h1, v);
        chk(v, 16'h6080);
    endtask

    // main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        t_reset();
        t_cfg();
        t_ext();
        t_lim();
        t_tout();
        complete_run();
    end

    // roughly three times the expected run length
    initial begin
        #400000;
        n_errors++;
        complete_run();
    end
endmodule

`default_nettype wire
